// File: core/hub_cfg_defines.svh
// Purpose: Offsets, field positions, reset values and timing counts of the config loader.
// Assumes: 100 MHz pclk, byte-wide image in an SPI EEPROM.
// Notes: Definitions only.
`ifndef HUB_CFG_DEFINES_SVH
`define HUB_CFG_DEFINES_SVH

`define HDR_BASIC 8'hd2
`define HDR_FULL 8'hd4
`define HDR_BLANK 8'hff
`define LEN_BASIC 5'd13
`define LEN_FULL 5'd24
`define LEN_IDS 5'd7
`define LEN_BLANK 5'd1
`define IMG_BYTES 24
`define WP_MAGIC 8'h42
`define DESC_HUB 8'h29
`define DESC_ZERO 8'h00
`define SPI_READ_CMD 24'h030000
`define CMD_FRAMES 5'd3

`define CLK_NS 10
`define SPI_HALF_NS 50
`define SPI_HALF_CYC ((`SPI_HALF_NS + `CLK_NS - 1) / `CLK_NS)

`define REG_STATUS 12'h000
`define REG_IDS 12'h004
`define REG_RELEASE 12'h008
`define REG_PORTS 12'h00c
`define REG_POWER 12'h010
`define REG_CONTROL 12'h014

`define CTRL_RELOAD 0
`define CTRL_RESET 32'h00000000

// Image byte positions.
`define B_FILTER 7
`define B_PORTS 8
`define B_DEMAND 9
`define B_CTRL 10
`define B_DELAY 11
`define B_FLAGS 12
`define F_DEMAND_FS 8
`define F_DEMAND_HS 9
`define F_CTRL_BASE 12
`define F_DELAY 16
`define F_FLAGS 17
`define F_OPTS 18
`define F_WP 19
`define F_USABLE 22
`define F_DETACH 23

// Flag byte and option byte bits.
`define FL_ZERO_DESC 7
`define FL_COMPOUND 6
`define FL_LOW_RATE 5
`define FL_NO_IND 4
`define FL_SHARED 2
`define OP_SENSE 3
`define OP_FAULT_OFF 1
`define OP_FAULT_PER 0

`endif

// File: core/hub_cfg_pkg.sv
// Purpose: Types shared by the configuration loader.
// Assumes: Constants live in hub_cfg_defines.svh.
// Notes: Types only.
package hub_cfg_pkg;
  typedef enum logic [1:0] {LD_IDLE, LD_SELECT, LD_SHIFT, LD_DONE} load_state_e;
  typedef logic [7:0] byte_t;
endpackage

// File: core/hub_eeprom_config_loader.sv
// Purpose: Reads the hub configuration image from an SPI EEPROM and decodes it.
// Assumes: SPI mode 0 EEPROM with a 16-bit address read command; APB register access.
// Notes: All outputs are registered; enumeration waits for config_ready.
//
// What this block does
// RL1: Header byte 0xd2 selects the basic extended layout for the following bytes.
// RL2: Header byte 0xd4 selects the full layout with speed and power fields.
// RL3: Maker identifier is bytes 1 and 2, byte 1 low.
// RL4: Part identifier is bytes 3 and 4, byte 4 high.
// RL5: Byte 5 is skipped; byte 6 is the release identifier high byte.
// RL6: Byte 7 holds enabled-port and disabled-port fault filter times, default 0x88.
// RL7: Basic byte 8 upper nibble is the usable port mask; port count is its popcount.
// RL8: Basic byte 8 lower nibble flags detachable logical ports, packed over usable ports.
// RL9: Basic byte 9 is upstream current demand in 2 mA units.
// RL10: Full layout reports byte 8 at full speed and byte 9 at high speed.
// RL11: Controller current in mA; basic layout takes byte 10.
// RL12: Full layout picks controller current from bytes 12 to 15 by speed and supply.
// RL13: Power-good delay in 2 ms units, byte 11 basic or 16 full.
// RL14: Flag bit 7 lets descriptor type 0 act as 0x29; otherwise stall it.
// RL15: Flag bit 6 marks compound membership in characteristics bit 2.
// RL16: Flag bit 5 forces full-speed-only operation.
// RL17: Flag bit 4 switches indicators off and clears characteristics bit 7.
// RL18: Flag bit 2 selects shared power switching, shown in characteristics bit 0 and, in the basic layout, bit 3.
// RL19: Image writer keeps flag bits 3, 1 and 0 at zero.
// RL20: Image writer zero-fills full layout bytes 10 and 11.
// RL21: Full layout byte 19 equal to 0x42 locks out further EEPROM writes.
// RL22: Full layout sense bit makes power switch outputs active high when set.
// RL23: Full layout fault-disable bit turns off overcurrent detection on all ports.
// RL24: A blank image of all ones enumerates as a vendor-class programming device.
// RL25: Read image from address zero after reset; hold enumeration until fields latched.
`timescale 1ns/1ps
`include "hub_cfg_defines.svh"
`default_nettype none

module hub_eeprom_config_loader
  import hub_cfg_pkg::*;
#(
  parameter int PORTS = 4,
  parameter logic [7:0] RELEASE_LOW = 8'h00 // Arbitrary value.
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic spi_sck,
  output logic spi_cs_n,
  output logic spi_mosi,
  input wire logic spi_miso,
  input wire logic high_speed_link,
  input wire logic self_powered_pin,
  input wire logic hub_desc_req,
  input wire logic [7:0] hub_desc_type,
  output logic hub_desc_accept,
  output logic hub_desc_stall,
  input wire logic [PORTS-1:0] indicator_request,
  output logic [PORTS-1:0] indicator_drive,
  input wire logic [PORTS-1:0] port_power_request,
  output logic [PORTS-1:0] port_power_ctl,
  input wire logic [PORTS-1:0] port_fault_pin,
  output logic [PORTS-1:0] port_fault_seen,
  output logic config_ready,
  output logic enumerate_hub,
  output logic vendor_class_mode,
  output logic write_locked,
  output logic low_rate_only,
  output logic accept_zero_descriptor_type,
  output logic [15:0] maker_identifier,
  output logic [15:0] part_identifier,
  output logic [15:0] release_identifier,
  output logic [3:0] on_port_fault_filter,
  output logic [3:0] off_port_fault_filter,
  output logic [PORTS-1:0] usable_port_mask,
  output logic [PORTS-1:0] detachable_port_mask,
  output logic [2:0] port_count,
  output logic [7:0] upstream_current_demand,
  output logic [7:0] hub_logic_current_field,
  output logic [7:0] power_settle_field,
  output logic [15:0] hub_characteristics
);

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers.

  logic [1:0] miso_sync;
  logic [1:0] self_sync;
  logic [PORTS-1:0] fault_meta;
  logic [PORTS-1:0] fault_sync;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      miso_sync <= 2'b00;
      self_sync <= 2'b00;
      fault_meta <= '0;
      fault_sync <= '0;
    end else begin
      miso_sync <= {miso_sync[0], spi_miso};
      self_sync <= {self_sync[0], self_powered_pin};
      fault_meta <= port_fault_pin;
      fault_sync <= fault_meta;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // APB slave.

  logic apb_access;
  logic reload_req;

  assign apb_access = psel & penable & pready;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
    end else begin
      pready <= psel & penable & ~pready;
    end
  end

  // The only writable bit is a self-clearing reload request.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reload_req <= 1'b0;
    end else begin
      reload_req <= apb_access & pwrite & (paddr == `REG_CONTROL) & pwdata[`CTRL_RELOAD];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
    end else if (psel & penable & ~pready) begin
      pslverr <= 1'b0;
      case (paddr)
        `REG_STATUS: prdata <= {26'h0, low_rate_only, write_locked, vendor_class_mode,
                                enumerate_hub, config_ready, ~spi_cs_n};
        `REG_IDS: prdata <= {part_identifier, maker_identifier};
        `REG_RELEASE: prdata <= {8'h00, on_port_fault_filter, off_port_fault_filter,
                                 release_identifier};
        `REG_PORTS: prdata <= {hub_characteristics, 5'h00, port_count,
                               detachable_port_mask, usable_port_mask};
        `REG_POWER: prdata <= {8'h00, power_settle_field, hub_logic_current_field,
                               upstream_current_demand};
        `REG_CONTROL: prdata <= `CTRL_RESET;
        default: begin
          prdata <= 32'h00000000;
          pslverr <= 1'b1;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // SPI reader.

  load_state_e state;
  logic [7:0] div_cnt;
  logic tick;
  logic [2:0] bit_idx;
  logic [4:0] frame;
  logic [4:0] img_len;
  logic [6:0] rx_sh;
  logic [23:0] tx_sh;
  byte_t img [`IMG_BYTES];
  byte_t rx_byte;
  logic [4:0] img_pos;

  assign tick = (div_cnt == 8'(`SPI_HALF_CYC - 1));
  assign rx_byte = {rx_sh, miso_sync[1]};
  assign img_pos = frame - `CMD_FRAMES;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_cnt <= 8'h00;
    end else if (tick || state == LD_IDLE || state == LD_DONE) begin
      div_cnt <= 8'h00;
    end else begin
      div_cnt <= div_cnt + 8'h01;
    end
  end

  // Read starts at address zero and streams on without re-addressing.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= LD_IDLE;
      spi_sck <= 1'b0;
      spi_cs_n <= 1'b1;
      spi_mosi <= 1'b0;
      bit_idx <= 3'h0;
      frame <= 5'h00;
      img_len <= `LEN_FULL;
      rx_sh <= 7'h00;
      tx_sh <= `SPI_READ_CMD;
      config_ready <= 1'b0;
    end else begin
      case (state)
        LD_IDLE: begin // see RL25
          spi_cs_n <= 1'b0;
          spi_mosi <= tx_sh[23];
          state <= LD_SELECT;
        end
        LD_SELECT: begin
          if (tick) begin
            state <= LD_SHIFT;
          end
        end
        LD_SHIFT: begin
          if (tick && !spi_sck) begin
            spi_sck <= 1'b1;
            rx_sh <= rx_byte[6:0];
            if (bit_idx == 3'h7 && frame == `CMD_FRAMES) begin
              case (rx_byte)
                `HDR_BASIC: img_len <= `LEN_BASIC; // see RL1
                `HDR_FULL: img_len <= `LEN_FULL; // see RL2
                `HDR_BLANK: img_len <= `LEN_BLANK; // see RL24
                default: img_len <= `LEN_IDS;
              endcase
            end
          end else if (tick) begin
            spi_sck <= 1'b0;
            bit_idx <= bit_idx + 3'h1;
            tx_sh <= {tx_sh[22:0], 1'b0};
            spi_mosi <= tx_sh[22];
            if (bit_idx == 3'h7) begin
              frame <= frame + 5'h01;
              if (frame + 5'h01 == `CMD_FRAMES + img_len) begin
                spi_cs_n <= 1'b1;
                state <= LD_DONE;
              end
            end
          end
        end
        LD_DONE: begin
          config_ready <= ~reload_req; // see RL25
          if (reload_req) begin
            state <= LD_IDLE;
            bit_idx <= 3'h0;
            frame <= 5'h00;
            img_len <= `LEN_FULL;
            tx_sh <= `SPI_READ_CMD;
          end
        end
        default: state <= LD_IDLE;
      endcase
    end
  end

  // Bytes an image does not carry keep their reset defaults or the values left by an earlier image.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < `IMG_BYTES; i++) begin
        img[i] <= 8'h00;
      end
      img[`B_FILTER] <= 8'h88;
      img[`F_DEMAND_FS] <= 8'h28;
      img[`F_DEMAND_HS] <= 8'h57;
      img[`F_CTRL_BASE] <= 8'h50;
      img[`F_CTRL_BASE + 1] <= 8'hae;
      img[`F_CTRL_BASE + 2] <= 8'h50;
      img[`F_CTRL_BASE + 3] <= 8'h64;
      img[`F_DELAY] <= 8'h32;
      img[`F_FLAGS] <= 8'h80;
      img[`F_USABLE] <= 8'h0f;
      img[`F_DETACH] <= 8'h0f;
    end else if (state == LD_SHIFT && tick && !spi_sck && bit_idx == 3'h7 &&
                 frame >= `CMD_FRAMES) begin
      img[img_pos] <= rx_byte;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Decode.

  logic full_fmt;
  logic blank_img;
  logic hs_eff;
  byte_t flags;
  byte_t opts;
  logic [PORTS-1:0] usable_v;
  logic [PORTS-1:0] detach_logical;
  logic [PORTS-1:0] detach_v;
  logic [2:0] count_v;
  logic shared_pwr;

  assign full_fmt = (img[0] != `HDR_BASIC); // see RL2
  assign blank_img = (img[0] == `HDR_BLANK);
  assign flags = full_fmt ? img[`F_FLAGS] : img[`B_FLAGS];
  assign opts = full_fmt ? img[`F_OPTS] : 8'h00;
  assign hs_eff = high_speed_link & ~flags[`FL_LOW_RATE]; // see RL16
  assign shared_pwr = flags[`FL_SHARED];
  assign usable_v = full_fmt ? img[`F_USABLE][PORTS-1:0] : img[`B_PORTS][7:4]; // see RL7
  assign detach_logical = full_fmt ? img[`F_DETACH][PORTS-1:0] : img[`B_PORTS][3:0];

  // Logical ports are counted over usable physical ports in ascending order.
  always_comb begin
    count_v = 3'h0;
    detach_v = '0;
    for (int p = 0; p < PORTS; p++) begin
      if (usable_v[p]) begin
        detach_v[p] = detach_logical[count_v[1:0]]; // see RL8
        count_v = count_v + 3'h1; // see RL7
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      maker_identifier <= 16'h0000;
      part_identifier <= 16'h0000;
      release_identifier <= 16'h0000;
      on_port_fault_filter <= 4'h8;
      off_port_fault_filter <= 4'h8;
      usable_port_mask <= '0;
      detachable_port_mask <= '0;
      port_count <= 3'h0;
      upstream_current_demand <= 8'h00;
      hub_logic_current_field <= 8'h00;
      power_settle_field <= 8'h00;
      hub_characteristics <= 16'h0000;
      accept_zero_descriptor_type <= 1'b1;
      low_rate_only <= 1'b0;
      write_locked <= 1'b0;
      enumerate_hub <= 1'b0;
      vendor_class_mode <= 1'b0;
    end else begin
      maker_identifier <= {img[2], img[1]}; // see RL3
      part_identifier <= {img[4], img[3]}; // see RL4
      release_identifier <= {img[6], RELEASE_LOW}; // see RL5
      on_port_fault_filter <= img[`B_FILTER][7:4]; // see RL6
      off_port_fault_filter <= img[`B_FILTER][3:0]; // see RL6
      usable_port_mask <= usable_v;
      detachable_port_mask <= detach_v;
      port_count <= count_v;
      if (!full_fmt) begin
        upstream_current_demand <= img[`B_DEMAND]; // see RL9
        hub_logic_current_field <= img[`B_CTRL]; // see RL11
        power_settle_field <= img[`B_DELAY]; // see RL13
      end else begin
        upstream_current_demand <= hs_eff ? img[`F_DEMAND_HS] : img[`F_DEMAND_FS]; // see RL10
        hub_logic_current_field <= img[`F_CTRL_BASE + {self_sync[1], hs_eff}]; // see RL12
        power_settle_field <= img[`F_DELAY]; // see RL13
      end
      hub_characteristics <= {8'h00, ~flags[`FL_NO_IND], 2'b00, // see RL17
                              full_fmt ? opts[`OP_FAULT_OFF] : 1'b0,
                              full_fmt ? opts[`OP_FAULT_PER] : ~shared_pwr,
                              flags[`FL_COMPOUND], // see RL15
                              1'b0, ~shared_pwr}; // see RL18
      accept_zero_descriptor_type <= flags[`FL_ZERO_DESC];
      low_rate_only <= flags[`FL_LOW_RATE]; // see RL16
      write_locked <= full_fmt & (img[`F_WP] == `WP_MAGIC); // see RL21
      enumerate_hub <= config_ready & ~blank_img; // see RL25
      vendor_class_mode <= config_ready & blank_img; // see RL24
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Port-side effects of the decoded settings.

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      indicator_drive <= '0;
      port_power_ctl <= '1;
      port_fault_seen <= '0;
      hub_desc_accept <= 1'b0;
      hub_desc_stall <= 1'b0;
    end else begin
      indicator_drive <= flags[`FL_NO_IND] ? '0 : indicator_request; // see RL17
      // Ports stay switched off until the sense of the switch is known.
      port_power_ctl <= (config_ready ? port_power_request : '0) ^
                        {PORTS{~opts[`OP_SENSE]}}; // see RL22
      port_fault_seen <= opts[`OP_FAULT_OFF] ? '0 : fault_sync; // see RL23
      hub_desc_accept <= hub_desc_req & ((hub_desc_type == `DESC_HUB) |
                         ((hub_desc_type == `DESC_ZERO) & flags[`FL_ZERO_DESC])); // see RL14
      hub_desc_stall <= hub_desc_req & (hub_desc_type != `DESC_HUB) &
                        ~((hub_desc_type == `DESC_ZERO) & flags[`FL_ZERO_DESC]); // see RL14
    end
  end

endmodule

`default_nettype wire

// File: verif/cfg_loader_checker.sv
// Purpose: Assertions on the configuration loader ports.
// Assumes: Single pclk domain, reset active low.
// Notes: Bound to the loader from the bench top file.
`timescale 1ns/1ps
`default_nettype none
module cfg_loader_checker #(
  parameter int PORTS = 4
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic spi_sck,
  input wire logic hub_desc_req,
  input wire logic [7:0] hub_desc_type,
  input wire logic hub_desc_accept,
  input wire logic hub_desc_stall,
  input wire logic [PORTS-1:0] indicator_drive,
  input wire logic [PORTS-1:0] port_fault_seen,
  input wire logic [PORTS-1:0] usable_port_mask,
  input wire logic [2:0] port_count,
  input wire logic config_ready,
  input wire logic enumerate_hub,
  input wire logic accept_zero_descriptor_type,
  input wire logic [15:0] hub_characteristics
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  chk_zero_accept: assert property (hub_desc_req && hub_desc_type == 8'h00
    && accept_zero_descriptor_type |=> hub_desc_accept && !hub_desc_stall)
    else $error("zero type not accepted");
  chk_zero_stall: assert property (hub_desc_req && hub_desc_type == 8'h00
    && !accept_zero_descriptor_type |=> hub_desc_stall && !hub_desc_accept)
    else $error("zero type not stalled");
  chk_indicators_off: assert property (config_ready && $past(config_ready, 2)
    && !hub_characteristics[7] && $stable(hub_characteristics) |-> indicator_drive == '0)
    else $error("indicators driven while suppressed");
  chk_fault_off: assert property (config_ready && hub_characteristics[4]
    && $stable(hub_characteristics) |=> port_fault_seen == '0)
    else $error("fault seen while detection off");
  chk_port_count: assert property (port_count == $countones(usable_port_mask))
    else $error("port count differs from mask");
  chk_enum_gate: assert property (enumerate_hub |-> config_ready || $past(config_ready))
    else $error("enumeration before image latched");
  // Half period of the serial clock is five pclk cycles.
  chk_sck_rate: assert property ($rose(spi_sck) |-> spi_sck [*5] ##1 !spi_sck)
    else $error("serial clock high time wrong");
  chk_apb_wait: assert property (psel && penable && !pready |=> pready)
    else $error("bus answer late");
endmodule
`default_nettype wire

// File: verif/spi_rom_model.sv
// Purpose: Behavioural SPI EEPROM for the loader bench.
// Assumes: Mode 0, read command with a 16-bit address.
// Notes: A released data line shows the inverse of its last bit.
`timescale 1ns/1ps
`default_nettype none
module spi_rom_model (
  input wire logic sck,
  input wire logic cs_n,
  input wire logic mosi,
  output logic miso
);
  logic [7:0] mem [0:31];
  logic [23:0] cmd;
  int n;
  initial miso = 1'b0;
  always @(negedge cs_n) n = 0;
  always @(posedge sck) begin
    if (!cs_n && n < 24) cmd <= {cmd[22:0], mosi};
    if (!cs_n) n <= n + 1;
  end
  // Data moves on the falling edge so it is settled at the next rise.
  always @(negedge sck or posedge cs_n) begin
    if (cs_n || n < 24 || cmd[23:16] != 8'h03) miso <= ~miso;
    else miso <= mem[5'(cmd[15:0] + (n - 24) / 8)][7 - (n - 24) % 8];
  end
endmodule
`default_nettype wire

// File: verif/testbench.sv
// Purpose: Self-checking bench for the hub configuration loader.
// Assumes: Images reach the loader through the EEPROM model.
// Notes: Expected values are built from the image array and the driven link, supply and port inputs.
`timescale 1ns/1ps
`include "hub_cfg_defines.svh"
`default_nettype none
`define CHK(n, e, a) begin comparisons++; if ((a) !== (e)) begin err_total++; \
  $display("mismatch %s exp %h got %h", n, e, a); end end
module testbench;
  import hub_cfg_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, err, spi_miso;
  logic high_speed_link = 0, self_powered_pin = 0, hub_desc_req = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, rd, prdata;
  logic [7:0] hub_desc_type = '0;
  logic [3:0] indicator_request = '0, port_power_request = '0, port_fault_pin = '0;
  logic pready, pslverr, spi_sck, spi_cs_n, spi_mosi, hub_desc_accept, hub_desc_stall;
  logic config_ready, enumerate_hub, vendor_class_mode, write_locked, low_rate_only;
  logic accept_zero_descriptor_type;
  logic [3:0] indicator_drive, port_power_ctl, port_fault_seen, on_port_fault_filter;
  logic [3:0] off_port_fault_filter, usable_port_mask, detachable_port_mask;
  logic [2:0] port_count;
  logic [7:0] upstream_current_demand, hub_logic_current_field, power_settle_field;
  logic [15:0] maker_identifier, part_identifier, release_identifier, hub_characteristics;
  int err_total = 0, comparisons = 0, seed = 32'h8d77, hs, sp, k;
  int im [0:23];
  int hdrs [6] = '{8'hd2, 8'hd4, 8'hff, 8'hd0, 8'hd4, 8'hd2};
  int dt [2] = '{0, 8'h29};
  hub_eeprom_config_loader u_dut (.*);
  spi_rom_model u_rom (.sck(spi_sck), .cs_n(spi_cs_n), .mosi(spi_mosi), .miso(spi_miso));
  always #5 pclk = ~pclk;
  task automatic complete_run();
    $display("errors %0d comparisons %0d", err_total, comparisons);
    if (err_total == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic hung();
    err_total++;
    complete_run();
  endtask
  task automatic await(ref logic s, input logic v, input int lim);
    k = 0;
    while (s !== v && k < lim) begin
      @(posedge pclk);
      k++;
    end
    if (k >= lim) hung();
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    psel <= 1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    await(pready, 1'b1, 50);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge pclk);
  endtask
  task automatic fill(input int h, input int j);
    foreach (im[i]) im[i] = (h == 8'hff) ? 8'hff : $random(seed) & 8'hff;
    im[0] = h;
    if (h == 8'hd2) im[12] &= 8'hf4;
    if (h == 8'hd4) begin
      im[17] &= 8'hf4;
      im[10] = 0;
      im[11] = 0;
      if (j == 4) im[19] = 8'h42;
    end
    foreach (im[i]) u_rom.mem[i] = im[i][7:0];
    hs = $random(seed) & 1;
    sp = $random(seed) & 1;
    high_speed_link <= hs[0];
    self_powered_pin <= sp[0];
    port_fault_pin <= 4'($random(seed));
  endtask
  task automatic check(input int h);
    int fb, full, hse, um, b43, dl, dm, np;
    `CHK("vendor", h == 8'hff, vendor_class_mode)
    `CHK("enum", h != 8'hff, enumerate_hub)
    if (h == 8'hff) return;
    `CHK("maker", 16'(im[2] * 256 + im[1]), maker_identifier)
    `CHK("part", 16'(im[4] * 256 + im[3]), part_identifier)
    `CHK("release", 16'(im[6] * 256), release_identifier)
    apb(0, `REG_IDS, 0);
    `CHK("ids reg", 32'(im[4] << 24 | im[3] << 16 | im[2] << 8 | im[1]), rd)
    if (h == 8'hd0) return;
    full = h == 8'hd4;
    fb = full ? im[17] : im[12];
    hse = hs && !fb[5];
    um = full ? im[22] & 15 : im[8] >> 4;
    b43 = full ? im[18] & 3 : !fb[2];
    // Logical flag n lands on the n-th usable physical port.
    dl = full ? im[23] : im[8];
    dm = 0;
    np = 0;
    for (int p = 0; p < 4; p++) begin
      if (um[p]) begin
        if (dl[np]) dm |= 1 << p;
        np++;
      end
    end
    `CHK("on filter", 4'(im[7] >> 4), on_port_fault_filter)
    `CHK("off filter", 4'(im[7]), off_port_fault_filter)
    `CHK("usable", 4'(um), usable_port_mask)
    `CHK("count", 3'($countones(4'(um))), port_count)
    `CHK("detach", 4'(dm), detachable_port_mask)
    `CHK("demand", 8'(full && !hse ? im[8] : im[9]), upstream_current_demand)
    `CHK("ctrl", 8'(full ? im[12 + sp * 2 + hse] : im[10]), hub_logic_current_field)
    `CHK("settle", 8'(full ? im[16] : im[11]), power_settle_field)
    `CHK("low rate", fb[5], low_rate_only)
    `CHK("zero ok", fb[7], accept_zero_descriptor_type)
    `CHK("locked", full && im[19] == 8'h42, write_locked)
    `CHK("chars", 16'(!fb[4] << 7 | b43 << 3 | fb[6] << 2 | !fb[2]),
      hub_characteristics & 16'h9f)
    indicator_request <= 4'($random(seed));
    port_power_request <= 4'($random(seed));
    repeat (3) @(posedge pclk);
    `CHK("ind", fb[4] ? 4'h0 : indicator_request, indicator_drive)
    `CHK("pwr", port_power_request ^ {4{~(full && im[18][3])}}, port_power_ctl)
    `CHK("fault", full && im[18][1] ? 4'h0 : port_fault_pin, port_fault_seen)
    foreach (dt[i]) begin
      hub_desc_req <= 1;
      hub_desc_type <= 8'(dt[i]);
      @(posedge pclk);
      hub_desc_req <= 0;
      @(posedge pclk);
      `CHK("accept", dt[i] != 0 || fb[7], hub_desc_accept)
      `CHK("stall", dt[i] == 0 && !fb[7], hub_desc_stall)
    end
  endtask
  //////////////////////////////////////////////////////////////////////
  initial begin
    fill(hdrs[0], 0);
    repeat (5) @(posedge pclk);
    presetn <= 1;
    for (int j = 0; j < 6; j++) begin
      if (j > 0) begin
        fill(hdrs[j], j);
        apb(1, `REG_CONTROL, 32'h1);
      end
      await(spi_cs_n, 1'b0, 50);
      await(spi_cs_n, 1'b1, 4000);
      await(config_ready, 1'b1, 50);
      repeat (3) @(posedge pclk);
      check(hdrs[j]);
    end
    apb(0, 12'h040, 0);
    `CHK("bad addr err", 1'b1, err)
    `CHK("bad addr data", 32'h0, rd)
    apb(0, `REG_STATUS, 0);
    `CHK("status", 2'b10, rd[1:0])
    complete_run();
  end
endmodule
bind hub_eeprom_config_loader cfg_loader_checker #(.PORTS(PORTS)) u_chk (.*);
`default_nettype wire
